// File: common/rx_status_pkg.sv
// Constants for the receive status encoder and self-test compare monitor.
// Assumes one receive character clock and an APB register port.
package rx_status_pkg;
  // Register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  // Control field positions
  localparam int CTRL_BIST_BIT = 0;
  localparam int CTRL_DEC_LSB = 1;
  localparam int CTRL_PAR_LSB = 3;
  localparam int CTRL_TYPE_BIT = 5;
  localparam int CTRL_CLK_LSB = 6;
  // Decoder on, parity off, Type-A, self-test off
  localparam logic [7:0] CTRL_RESET = 8'h02;
  // Three-level select encodings
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  // Status codes
  localparam logic [2:0] ST_DATA = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_EB_FAULT = 3'h2;
  localparam logic [2:0] ST_FRAMING = 3'h3;
  localparam logic [2:0] ST_VIOL = 3'h4;
  localparam logic [2:0] ST_LOCK = 3'h5;
  localparam logic [2:0] ST_DISP = 3'h6;
  localparam logic [2:0] ST_BIST_OK = 3'h1;
  localparam logic [2:0] ST_LAST_GOOD = 3'h2;
  localparam logic [2:0] ST_LAST_BAD = 3'h4;
  localparam logic [2:0] ST_TEST_START_STATE = 3'h5;
  localparam logic [2:0] ST_BIST_ERR = 3'h6;
  localparam logic [2:0] ST_BIST_WAIT = 3'h7;
  // Self-test figures
  localparam logic signed [7:0] ERR_LIMIT = 8'sh10;
  // Floor of the error balance; it saturates so a long clean run never wraps
  localparam logic signed [7:0] DIFF_FLOOR = 8'sh80;
  localparam logic [3:0] RECENTER_CHARS = 4'h9;
  localparam logic [7:0] SEQ_LAST = 8'hFE;
  localparam logic [7:0] START_CHAR = 8'h00;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  // Substitute for a disparity-error character (C4.7)
  localparam logic [7:0] REPLACE_CHAR = 8'hE4;
  typedef enum logic [1:0] {
    test_start_state = 2'b00,
    test_wait_state = 2'b01,
    test_compare_state = 2'b10
  } bist_state_t;
endpackage : rx_status_pkg

// File: core/rx_status_bist_monitor.sv
// Receive status encoder with self-test compare monitor and APB control.
// Assumes character flags arrive on pclk; PLL lock loss is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module rx_status_bist_monitor
  import rx_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic char_valid,
  input wire logic [9:0] char_raw,
  input wire logic [7:0] char_data,
  input wire logic char_is_special,
  input wire logic char_is_framing,
  input wire logic char_code_viol,
  input wire logic char_disp_err,
  input wire logic eb_fault,
  input wire logic pll_lock_lost,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic [2:0] rx_char_status,
  output logic rx_parity_out,
  output logic rx_parity_out_oe
);
  // Next LFSR word of the expected pattern
  function automatic logic [7:0] lfsr_step(input logic [7:0] x);
    lfsr_step = {x[6:0], ^(x & LFSR_TAPS)};
  endfunction : lfsr_step

  logic pll_meta_reg; // First stage, read only by second
  logic pll_sync_reg; // Synchronised lock loss
  logic [7:0] ctrl_reg; // Control bits
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [3:0] recenter_reg; // Characters left to re-centre
  bist_state_t state_reg;
  bist_state_t state_next;
  logic [7:0] lfsr_reg; // Expected next character
  logic [7:0] count_reg; // Position in sequence
  logic signed [7:0] diff_reg; // Errors minus matches
  logic signed [7:0] diff_next;
  logic [2:0] status_reg;
  logic [7:0] data_reg;
  logic valid_reg;
  logic par_reg;
  logic par_oe_reg;
  logic [2:0] bist_code;
  logic [2:0] norm_code;
  logic [2:0] out_status;
  logic [7:0] out_data;
  logic par_bit;
  logic bist_en;
  logic [1:0] dec_sel;
  logic [1:0] par_sel;
  logic type_b;
  logic match;
  logic hold_start;

  assign bist_en = ctrl_reg[CTRL_BIST_BIT];
  assign dec_sel = ctrl_reg[CTRL_DEC_LSB +: 2];
  assign par_sel = ctrl_reg[CTRL_PAR_LSB +: 2];
  assign type_b = ctrl_reg[CTRL_TYPE_BIT];
  assign match = (char_data == lfsr_reg) && !char_code_viol;
  // Any of these pins the machine to its start state
  assign hold_start = pll_sync_reg || eb_fault || (recenter_reg != 4'h0) || !bist_en;

  // Two-flop synchroniser for the asynchronous lock-loss pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_meta_reg <= 1'b0;
      pll_sync_reg <= 1'b0;
    end else begin
      pll_meta_reg <= pll_lock_lost;
      pll_sync_reg <= pll_meta_reg;
    end
  end

  // APB slave: answers one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      if (paddr == CTRL_ADDR) begin
        // Control word
        if (pwrite) begin
          ctrl_reg <= pwdata[7:0];
        end else begin
          prdata_reg <= {24'h0, ctrl_reg};
        end
      end else if (paddr == STAT_ADDR) begin
        // Read-only status; writes ignored
        if (!pwrite) begin
          prdata_reg <= {diff_reg, count_reg, 5'h0, status_reg, 6'h0, state_reg};
        end
      end else begin
        // Unmapped: error answer
        pslverr_reg <= 1'b1;
      end
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Re-centring hold after a buffer fault, counted in characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recenter_reg <= 4'h0;
    end else if (eb_fault) begin
      recenter_reg <= RECENTER_CHARS;
    end else if (char_valid && recenter_reg != 4'h0) begin
      recenter_reg <= recenter_reg - 4'h1;
    end
  end

  // Error balance after this character; held at its floor, since a wrap would fake an excess
  always_comb begin
    diff_next = diff_reg;
    if (state_reg == test_compare_state && char_valid) begin
      diff_next = !match ? diff_reg + 8'sh01 :
                  (diff_reg == DIFF_FLOOR) ? diff_reg : diff_reg - 8'sh01;
    end
  end

  // Compare machine next state
  always_comb begin
    state_next = state_reg;
    if (hold_start) begin
      state_next = test_start_state;
    end else if (char_valid) begin
      case (state_reg)
        test_start_state: state_next = test_wait_state;
        test_wait_state: begin
          if (char_data == START_CHAR && !char_code_viol) begin
            state_next = test_compare_state;
          end
        end
        test_compare_state: begin
          if (count_reg == SEQ_LAST || diff_next > ERR_LIMIT) begin
            state_next = test_wait_state;
          end
        end
        default: state_next = test_start_state;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= test_start_state;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pattern generator, position and error balance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_reg <= LFSR_SEED;
      count_reg <= 8'h0;
      diff_reg <= 8'sh00;
    end else if (state_next != test_compare_state) begin
      // Restart fresh on each sequence
      lfsr_reg <= LFSR_SEED;
      count_reg <= 8'h0;
      diff_reg <= 8'sh00;
    end else if (state_reg == test_compare_state && char_valid) begin
      lfsr_reg <= lfsr_step(lfsr_reg);
      count_reg <= count_reg + 8'h1;
      diff_reg <= diff_next;
    end
  end

  // Self-test code for the current character
  always_comb begin
    case (state_reg)
      test_wait_state: bist_code = ST_BIST_WAIT;
      test_compare_state: begin
        if (count_reg == SEQ_LAST) begin
          bist_code = match ? ST_LAST_GOOD : ST_LAST_BAD;
        end else begin
          bist_code = match ? ST_BIST_OK : ST_BIST_ERR;
        end
      end
      default: bist_code = ST_TEST_START_STATE;
    endcase
    // Faults seen this very cycle still report start
    if (hold_start) begin
      bist_code = ST_TEST_START_STATE;
    end
  end

  // Normal status, most urgent condition first
  always_comb begin
    if (pll_sync_reg) begin
      norm_code = ST_LOCK;
    end else if (eb_fault && !type_b) begin
      norm_code = ST_EB_FAULT;
    end else if (char_code_viol) begin
      norm_code = ST_VIOL;
    end else if (char_is_framing) begin
      norm_code = ST_FRAMING;
    end else if (char_disp_err) begin
      norm_code = ST_DISP;
    end else if (char_is_special) begin
      norm_code = ST_SPECIAL;
    end else begin
      norm_code = ST_DATA;
    end
  end

  // Output selection by mode
  always_comb begin
    out_data = char_data;
    if (bist_en) begin
      out_status = bist_code;
    end else begin
      out_status = norm_code;
    end
    if (dec_sel == SEL_LOW) begin
      // Raw character across data, and across the low status bits when self-test is off
      out_data = char_raw[9:2];
      out_status[1:0] = {char_raw[0], char_raw[1]};
      if (!bist_en) begin
        out_status[2] = char_is_framing;
      end else begin
        out_status = bist_code;
      end
    end else if (!bist_en && norm_code == ST_DISP) begin
      out_data = REPLACE_CHAR;
    end
  end

  // Odd parity over the selected bits
  always_comb begin
    if (par_sel == SEL_HIGH) begin
      par_bit = ~^{out_data, out_status};
    end else if (dec_sel == SEL_LOW) begin
      par_bit = ~^{out_data, out_status[1:0]};
    end else begin
      par_bit = ~^out_data;
    end
  end

  // Output register, loaded once per character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_reg <= 1'b0;
      data_reg <= 8'h0;
      status_reg <= ST_DATA;
      par_reg <= 1'b0;
    end else begin
      valid_reg <= char_valid;
      if (char_valid) begin
        data_reg <= out_data;
        status_reg <= out_status;
        par_reg <= par_bit;
      end
    end
  end

  // Parity driver enable follows the select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_oe_reg <= 1'b0;
    end else begin
      par_oe_reg <= (par_sel != SEL_LOW);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_char_valid = valid_reg;
  assign rx_char_data = data_reg;
  assign rx_char_status = status_reg;
  assign rx_parity_out = par_reg;
  assign rx_parity_out_oe = par_oe_reg;

  // Checks
  chk_lock_start: assert property (@(posedge pclk) disable iff (!presetn)
    pll_sync_reg |=> state_reg == test_start_state)
    else $error("lock loss did not force start");
  chk_err_limit: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == test_compare_state && char_valid && !hold_start && diff_next > ERR_LIMIT
    |=> state_reg == test_wait_state)
    else $error("error excess did not force wait");
  chk_recenter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    eb_fault |=> state_reg == test_start_state [*2])
    else $error("buffer fault did not hold start");
  chk_parity_off: assert property (@(posedge pclk) disable iff (!presetn)
    par_sel == SEL_LOW [*2] |-> !rx_parity_out_oe)
    else $error("parity driver on while disabled");
  chk_bypass_top: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && dec_sel == SEL_LOW && !bist_en
    |=> rx_char_status[2] == $past(char_is_framing))
    else $error("bypass top status bit wrong");
  chk_data_code: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && !bist_en && dec_sel != SEL_LOW && !pll_sync_reg && !eb_fault
    && !char_code_viol && !char_is_framing && !char_disp_err && !char_is_special
    |=> rx_char_status == ST_DATA && rx_char_valid)
    else $error("plain data code wrong");
  chk_lock_code: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && !bist_en && dec_sel != SEL_LOW && pll_sync_reg
    |=> rx_char_status == ST_LOCK)
    else $error("lock loss code wrong");
  chk_disp_sub: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && !bist_en && dec_sel != SEL_LOW && norm_code == ST_DISP
    |=> rx_char_data == REPLACE_CHAR)
    else $error("disparity character not replaced");
  chk_wait_code: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && bist_en && state_reg == test_wait_state && !hold_start
    |=> rx_char_status == ST_BIST_WAIT)
    else $error("wait code wrong");
  chk_mismatch_code: assert property (@(posedge pclk) disable iff (!presetn)
    char_valid && bist_en && state_reg == test_compare_state && !hold_start
    && !match && count_reg != SEQ_LAST |=> rx_char_status == ST_BIST_ERR)
    else $error("mismatch code wrong");
  cov_compare: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == test_wait_state ##1 state_reg == test_compare_state);
  cov_last_good: cover property (@(posedge pclk) disable iff (!presetn)
    rx_char_status == ST_LAST_GOOD && bist_en);
  cov_err_exit: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == test_compare_state && diff_next > ERR_LIMIT);
endmodule : rx_status_bist_monitor
`default_nettype wire

// File: verif/rx_host_model.sv
// Host-side model that latches each character word and its status.
// Assumes the parity pin floats, with no pull resistor, when undriven.
`timescale 1ns/1ps
`default_nettype none
module rx_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic [2:0] rx_char_status,
  input wire logic rx_parity_out,
  input wire logic rx_parity_out_oe,
  output logic [7:0] host_data,
  output logic [2:0] host_status,
  output logic host_parity
);
  logic last_par; // Last level seen while driven
  // Floating pin shows the inverse, so a stale level never passes
  assign host_parity = rx_parity_out_oe ? rx_parity_out : ~last_par;
  // Word latch on each valid pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data <= 8'h00;
      host_status <= 3'h0;
    end else if (rx_char_valid) begin
      host_data <= rx_char_data;
      host_status <= rx_char_status;
    end
  end
  // Remember the driven parity level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_par <= 1'b0;
    end else if (rx_parity_out_oe) begin
      last_par <= rx_parity_out;
    end
  end
endmodule : rx_host_model
`default_nettype wire

// File: verif/rx_status_bist_monitor_bench.sv
// Bench for the receive status monitor: APB control and character stream.
// Assumes one APB wait state and one cycle of character latency.
`timescale 1ns/1ps
`default_nettype none
module rx_status_bist_monitor_bench;
  import rx_status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite; // Bus and clock
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic cv, sp, fr, cvl, de, eb, pll; // Character flags and events
  logic [9:0] raw;
  logic [7:0] dat, lf, od, h_data;
  logic ov, op, oe, h_par;
  logic [2:0] os, h_status;
  int n_fail, total_checks, cyc;
  rx_status_bist_monitor rx_status_bist_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .char_valid(cv),
    .char_raw(raw), .char_data(dat), .char_is_special(sp), .char_is_framing(fr),
    .char_code_viol(cvl), .char_disp_err(de), .eb_fault(eb), .pll_lock_lost(pll),
    .rx_char_valid(ov), .rx_char_data(od), .rx_char_status(os), .rx_parity_out(op),
    .rx_parity_out_oe(oe));
  rx_host_model rx_host_model_inst (.pclk(pclk), .presetn(presetn), .rx_char_valid(ov),
    .rx_char_data(od), .rx_char_status(os), .rx_parity_out(op), .rx_parity_out_oe(oe),
    .host_data(h_data), .host_status(h_status), .host_parity(h_par));
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Verdict, reached once from the sequence or the timeout
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // Hang guard, well above the run length
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // One compare for every value kind, widened to a word
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // APB transfer; waits on pready, the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Control word with the receive clock select held at MID
  function automatic logic [31:0] ctl(logic b, logic [1:0] dm, logic [1:0] pm, logic t);
    return {24'h0, SEL_MID, t, pm, dm, b};
  endfunction : ctl
  // One character in, host word compared when k is set
  task automatic ch(input logic [7:0] d, input logic [4:0] f, input logic [2:0] es,
                    input logic [7:0] ed, input logic k);
    @(posedge pclk);
    cv <= 1'b1;
    dat <= d;
    {sp, fr, cvl, de, eb} <= f;
    @(posedge pclk);
    cv <= 1'b0;
    {sp, fr, cvl, de, eb} <= 5'h00;
    #1;
    if (k) begin
      chk("valid", 32'h1, {31'h0, ov});
    end
    @(posedge pclk);
    #1;
    if (k) begin
      chk("valid end", 32'h0, {31'h0, ov});
      chk("status", {29'h0, es}, {29'h0, h_status});
      chk("data", {24'h0, ed}, {24'h0, h_data});
    end
  endtask : ch
  // Lock loss held past the two-flop synchroniser
  task automatic lock(input logic v);
    @(posedge pclk);
    pll <= v;
    repeat (3) @(posedge pclk);
  endtask : lock
  // Main sequence
  initial begin
    {psel, penable, pwrite, cv, sp, fr, cvl, de, eb, pll} = 10'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    raw = 10'h2A5;
    dat = 8'h00;
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RESET}, rd);
    chk("parity oe", 32'h0, {31'h0, oe});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test reset done");
    ch(8'h3C, 5'h00, ST_DATA, 8'h3C, 1);
    ch(8'hBC, 5'h10, ST_SPECIAL, 8'hBC, 1);
    ch(8'hBC, 5'h08, ST_FRAMING, 8'hBC, 1);
    ch(8'h11, 5'h04, ST_VIOL, 8'h11, 1);
    ch(8'h22, 5'h02, ST_DISP, REPLACE_CHAR, 1);
    ch(8'h33, 5'h01, ST_EB_FAULT, 8'h33, 1);
    ch(8'h44, 5'h0C, ST_VIOL, 8'h44, 1);
    ch(8'h45, 5'h05, ST_EB_FAULT, 8'h45, 1);
    lock(1'b1);
    ch(8'h55, 5'h15, ST_LOCK, 8'h55, 1);
    lock(1'b0);
    apb(1'b1, CTRL_ADDR, ctl(0, SEL_MID, SEL_LOW, 1));
    ch(8'h66, 5'h11, ST_SPECIAL, 8'h66, 1);
    $display("test normal codes done");
    apb(1'b1, CTRL_ADDR, ctl(0, SEL_MID, SEL_HIGH, 0));
    ch(8'h3C, 5'h00, ST_DATA, 8'h3C, 1);
    chk("parity", {31'h0, ~^{8'h3C, ST_DATA}}, {31'h0, h_par});
    apb(1'b1, CTRL_ADDR, ctl(0, SEL_MID, SEL_MID, 0));
    ch(8'h3D, 5'h00, ST_DATA, 8'h3D, 1);
    chk("parity mid", {31'h0, ~^8'h3D}, {31'h0, h_par});
    apb(1'b1, CTRL_ADDR, ctl(0, SEL_LOW, SEL_LOW, 0));
    // Driver enable settles one edge after the write, so look past that edge
    #1;
    chk("parity oe", 32'h0, {31'h0, oe});
    ch(8'h00, 5'h00, {1'b0, raw[0], raw[1]}, raw[9:2], 1);
    ch(8'h00, 5'h08, {1'b1, raw[0], raw[1]}, raw[9:2], 1);
    // Let the re-centring hold from the buffer-fault characters run out
    repeat (9) ch(8'h00, 5'h00, {1'b0, raw[0], raw[1]}, raw[9:2], 1);
    $display("test parity and bypass done");
    apb(1'b1, CTRL_ADDR, ctl(1, SEL_LOW, SEL_LOW, 0));
    ch(8'h77, 5'h00, ST_TEST_START_STATE, raw[9:2], 1);
    apb(1'b1, CTRL_ADDR, ctl(1, SEL_MID, SEL_LOW, 0));
    ch(8'h77, 5'h00, ST_BIST_WAIT, 8'h77, 1);
    // Two full patterns; the last one lands on the sequence end count
    for (int p = 0; p < 2; p++) begin
      ch(START_CHAR, 5'h00, ST_BIST_WAIT, START_CHAR, 0);
      lf = LFSR_SEED;
      for (int i = 0; i < 254; i++) begin
        ch(lf, 5'h00, ST_BIST_OK, lf, 1);
        lf = {lf[6:0], ^(lf & LFSR_TAPS)};
      end
      // Second pass spoils its final character
      if (p == 0) begin
        ch(lf, 5'h00, ST_LAST_GOOD, lf, 1);
      end else begin
        ch(~lf, 5'h00, ST_LAST_BAD, ~lf, 1);
      end
    end
    ch(8'h77, 5'h00, ST_BIST_WAIT, 8'h77, 1);
    $display("test pattern done");
    ch(START_CHAR, 5'h00, ST_BIST_WAIT, START_CHAR, 0);
    // Zero never appears in the pattern, so each is a miss
    repeat (17) ch(8'h00, 5'h00, ST_BIST_ERR, 8'h00, 1);
    ch(8'h77, 5'h00, ST_BIST_WAIT, 8'h77, 1);
    $display("test error balance done");
    ch(START_CHAR, 5'h00, ST_BIST_WAIT, START_CHAR, 0);
    lock(1'b1);
    ch(LFSR_SEED, 5'h00, ST_TEST_START_STATE, LFSR_SEED, 1);
    lock(1'b0);
    ch(8'h77, 5'h00, ST_TEST_START_STATE, 8'h77, 0);
    ch(START_CHAR, 5'h00, ST_BIST_WAIT, START_CHAR, 0);
    ch(LFSR_SEED, 5'h01, ST_TEST_START_STATE, LFSR_SEED, 1);
    ch(8'h02, 5'h00, ST_TEST_START_STATE, 8'h02, 1);
    $display("test lock and buffer fault done");
    final_report();
  end
endmodule : rx_status_bist_monitor_bench
`default_nettype wire
